/* File: logic/ppgss_pkg.sv */
package ppgss_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int SCLK_HZ = 32_000;
    localparam int TICK_CYC = CLK_HZ / SCLK_HZ;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int T_OFFSET_US = 25;
    localparam int T_WIDTH_US = 3;
    localparam int T_PERIOD_US = 19;
    localparam int T_PROC_A_US = 68;
    localparam int T_PROC_B_US = 20;
    localparam int T_SLEEP_US = 200;
    localparam int OFFSET_CYC = T_OFFSET_US * CYC_PER_US;
    localparam int WIDTH_CYC = T_WIDTH_US * CYC_PER_US;
    localparam int GAP_CYC = (T_PERIOD_US - T_WIDTH_US) * CYC_PER_US;
    localparam int PROC_A_CYC = T_PROC_A_US * CYC_PER_US;
    localparam int PROC_B_CYC = T_PROC_B_US * CYC_PER_US;
    localparam int SLEEP_CYC = T_SLEEP_US * CYC_PER_US;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h10;
    localparam logic [7:0] ADDR_CFG = 8'h11;
    localparam logic [7:0] ADDR_RATE = 8'h12;
    localparam logic [7:0] ADDR_PULSE_A = 8'h31;
    localparam logic [7:0] ADDR_PULSE_B = 8'h36;
    localparam logic [7:0] ADDR_SLOT_SYNC = 8'h38;
    localparam logic [7:0] ADDR_EXT_SYNC = 8'h4f;
    localparam logic [7:0] ADDR_WIDE_A_LO = 8'h70;
    localparam logic [7:0] ADDR_WIDE_A_HI = 8'h71;
    localparam logic [7:0] ADDR_WIDE_B_LO = 8'h72;
    localparam logic [7:0] ADDR_WIDE_B_HI = 8'h73;
    localparam logic [7:0] ADDR_NARROW_A = 8'h74;
    localparam logic [7:0] ADDR_NARROW_B = 8'h75;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Field positions and encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_PROGRAM = 2'h1;
    localparam logic [1:0] MODE_SAMPLE = 2'h2;
    localparam int CFG_AVG_A_LSB = 0;
    localparam int CFG_AVG_B_LSB = 4;
    localparam int CFG_EN_A = 8;
    localparam int CFG_EN_B = 9;
    localparam int CFG_FIFO_SEL = 12;
    localparam int CFG_WIDE_RAW = 13;
    localparam int SYNC_BUF_BIT = 1;
    localparam int SYNC_SEL_BIT = 2;
    localparam int PULSE_CNT_LSB = 8;

    // ------------------------------------------------------------
    // Data widths and carriers
    // ------------------------------------------------------------
    localparam int ADC_W = 14;
    localparam int BURST_W = 20;
    localparam int SACC_W = 27;
    localparam int WIDE_W = 32;
    localparam int NARROW_W = 16;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ppgss_regreq_t;

    typedef struct packed {
        logic slot;
        logic [WIDE_W-1:0] data;
    } ppgss_word_t;

endpackage

/* File: logic/ppgss_buf.sv */
`timescale 1ns/1ps
module ppgss_buf #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("ppgss_buf depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt != (PW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign empty = (cnt == '0);
    assign out_data = mem[rp];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            if (push && !pop) begin
                cnt <= cnt + 1'b1;
            end else if (pop && !push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

endmodule // ppgss_buf

/* File: logic/ppgss_sequencer.sv */
// Functional notes
// (RULE_01) Mode zero: standby, no sampling, registers kept.
// (RULE_02) Comes out of reset in standby.
// (RULE_03) Mode one: programming, no pulsing.
// (RULE_04) Host passes through programming between states.
// (RULE_05) Mode two: sampling, pulses fired, data collected.
// (RULE_06) Sample sums one to 255 pulses.
// (RULE_07) Optional power-of-two averaging, outputs every N.
// (RULE_08) Sample rate divides the 32 kHz tick.
// (RULE_09) Host keeps period above slots plus sleep.
// (RULE_10) External sync rising edge starts next period.
// (RULE_11) Sync waits one to two ticks, then starts.
// (RULE_12) Host enables sync in prescribed order.
// (RULE_13) Sync source never exceeds maximum rate.
// (RULE_14) Each slot bursts its own emitter, windowed.
// (RULE_15) Converter results summed per slot, 20 bits.
// (RULE_16) Burst sum saturates at 20 bits.
// (RULE_17) Sample sum to 27 bits, zero-extended to 32.
// (RULE_18) Narrow outputs decimated and clipped to 16 bits.
// (RULE_19) Control bit clear gives averaged wide data.
// (RULE_20) Both slots feed FIFO only with equal factors.
// (RULE_21) Pulse count from upper byte of register.
// (RULE_22) Processing time 68 us slot A, 20 us B.
// (RULE_23) At least 200 us sleep between periods.
// (RULE_24) Slot A runs before slot B.
`timescale 1ns/1ps
module ppgss_sequencer #(
    parameter int PROC_A_CYC = ppgss_pkg::PROC_A_CYC,
    parameter int SLEEP_CYC = ppgss_pkg::SLEEP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire ppgss_pkg::ppgss_regreq_t reg_req,
    output logic [15:0] reg_rdata,
    // Sync pin and converter
    input wire logic int_pin,
    input wire logic adc_valid,
    input wire logic [ppgss_pkg::ADC_W-1:0] adc_data,
    // Emitters and sensing window
    output logic red_emitter,
    output logic infrared_emitter,
    output logic afe_window,
    // FIFO word stream
    output logic out_valid,
    input wire logic out_ready,
    output ppgss_pkg::ppgss_word_t out_word
);
    if (PROC_A_CYC < 1 || PROC_A_CYC > 65536 || SLEEP_CYC < 1 ||
        SLEEP_CYC > 65536) begin : g_bad_param
        $error("ppgss_sequencer counts must fit sixteen bits");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_OFFSET, ST_PULSE, ST_GAP, ST_PROC, ST_SLEEP
    } ppgss_state_t;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0] mode;
    logic [15:0] cfg;
    logic [15:0] rate;
    logic [15:0] pulse_a;
    logic [15:0] pulse_b;
    logic [15:0] slot_sync;
    logic [15:0] ext_sync;

    wire wr_mode = reg_req.wr && reg_req.addr == ppgss_pkg::ADDR_MODE;
    wire wr_cfg = reg_req.wr && reg_req.addr == ppgss_pkg::ADDR_CFG;
    wire wr_rate = reg_req.wr && reg_req.addr == ppgss_pkg::ADDR_RATE;
    wire wr_pa = reg_req.wr && reg_req.addr == ppgss_pkg::ADDR_PULSE_A;
    wire wr_pb = reg_req.wr && reg_req.addr == ppgss_pkg::ADDR_PULSE_B;
    wire wr_ss = reg_req.wr && reg_req.addr == ppgss_pkg::ADDR_SLOT_SYNC;
    wire wr_es = reg_req.wr && reg_req.addr == ppgss_pkg::ADDR_EXT_SYNC;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode <= ppgss_pkg::MODE_STANDBY; // RULE_02
            cfg <= ppgss_pkg::REG_RESET;
            rate <= ppgss_pkg::REG_RESET;
            pulse_a <= ppgss_pkg::REG_RESET;
            pulse_b <= ppgss_pkg::REG_RESET;
            slot_sync <= ppgss_pkg::REG_RESET;
            ext_sync <= ppgss_pkg::REG_RESET;
        end else begin
            if (wr_mode) mode <= reg_req.wdata[1:0];
            if (wr_cfg) cfg <= reg_req.wdata;
            if (wr_rate) rate <= reg_req.wdata;
            if (wr_pa) pulse_a <= reg_req.wdata;
            if (wr_pb) pulse_b <= reg_req.wdata;
            if (wr_ss) slot_sync <= reg_req.wdata;
            if (wr_es) ext_sync <= reg_req.wdata;
        end
    end

    wire is_sample = (mode == ppgss_pkg::MODE_SAMPLE); // RULE_05
    wire en_a = cfg[ppgss_pkg::CFG_EN_A];
    wire en_b = cfg[ppgss_pkg::CFG_EN_B];
    wire [2:0] lg_a = cfg[ppgss_pkg::CFG_AVG_A_LSB +: 3];
    wire [2:0] lg_b = cfg[ppgss_pkg::CFG_AVG_B_LSB +: 3];
    wire sync_en = ext_sync[ppgss_pkg::SYNC_SEL_BIT] &&
                   ext_sync[ppgss_pkg::SYNC_BUF_BIT]; // RULE_10

    // ------------------------------------------------------------
    // Sample clock tick, rate divider and external sync
    // ------------------------------------------------------------
    logic [11:0] tick_cnt;
    logic [15:0] rate_cnt;
    logic int_prev;
    logic sync_arm;
    logic sync_half;
    logic pending;
    logic start_go;

    wire tick = (tick_cnt == 12'(ppgss_pkg::TICK_CYC - 1));
    wire [16:0] rate_next = {1'b0, rate_cnt} + 17'h00001;
    wire rate_hit = rate_next >= {1'b0, rate};
    wire timer_fire = tick && is_sample && !sync_en && rate_hit; // RULE_08
    wire sync_rise = sync_en && is_sample && int_pin && !int_prev;
    wire sync_fire = sync_arm && tick && sync_half; // RULE_11
    wire next_pending = (pending && !start_go && is_sample) ||
                        timer_fire || sync_fire;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= '0;
            rate_cnt <= '0;
            int_prev <= 1'b0;
            sync_arm <= 1'b0;
            sync_half <= 1'b0;
            pending <= 1'b0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
            int_prev <= int_pin;
            pending <= next_pending;
            if (!is_sample || sync_en) begin
                rate_cnt <= '0;
            end else if (tick) begin
                rate_cnt <= rate_hit ? '0 : rate_next[15:0];
            end
            if (!sync_en || !is_sample) begin
                sync_arm <= 1'b0;
            end else if (sync_rise) begin
                sync_arm <= 1'b1; // RULE_10
                sync_half <= 1'b0;
            end else if (sync_arm && tick) begin
                sync_half <= 1'b1;
                if (sync_half) sync_arm <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Slot sequencer
    // ------------------------------------------------------------
    ppgss_state_t state;
    ppgss_state_t next_state;
    logic cur_slot;
    logic next_slot;
    logic [15:0] timer;
    logic [15:0] next_timer;
    logic [7:0] left;
    logic [7:0] next_left;
    logic slot_end;
    logic buf_empty;

    wire [7:0] cnt_raw = cur_slot ? pulse_b[ppgss_pkg::PULSE_CNT_LSB +: 8]
                                  : pulse_a[ppgss_pkg::PULSE_CNT_LSB +: 8];
    wire [7:0] cnt_use = (cnt_raw == 8'h00) ? 8'h01 : cnt_raw; // RULE_21
    wire timer_done = (timer == 16'h0000);
    wire [15:0] proc_cyc = cur_slot ? 16'(ppgss_pkg::PROC_B_CYC - 1)
                                    : 16'(PROC_A_CYC - 1); // RULE_22

    assign start_go = state == ST_IDLE && is_sample && pending &&
                      buf_empty && (en_a || en_b);

    always_comb begin
        next_state = state;
        next_slot = cur_slot;
        next_timer = timer_done ? timer : timer - 16'h0001;
        next_left = left;
        slot_end = 1'b0;
        if (!is_sample) begin
            next_state = ST_IDLE; // RULE_01 RULE_03
        end else begin
            case (state)
                ST_IDLE: if (start_go) begin
                    next_state = ST_OFFSET;
                    next_slot = !en_a; // RULE_24
                    next_timer = 16'(ppgss_pkg::OFFSET_CYC - 1);
                end
                ST_OFFSET: if (timer_done) begin
                    next_state = ST_PULSE;
                    next_timer = 16'(ppgss_pkg::WIDTH_CYC - 1);
                    next_left = cnt_use; // RULE_06
                end
                ST_PULSE: if (timer_done) begin
                    next_state = ST_GAP;
                    next_timer = 16'(ppgss_pkg::GAP_CYC - 1);
                end
                ST_GAP: if (timer_done) begin
                    if (left > 8'h01) begin
                        next_state = ST_PULSE; // RULE_06
                        next_left = left - 8'h01;
                        next_timer = 16'(ppgss_pkg::WIDTH_CYC - 1);
                    end else begin
                        next_state = ST_PROC;
                        next_timer = proc_cyc; // RULE_22
                    end
                end
                ST_PROC: if (timer_done) begin
                    slot_end = 1'b1;
                    if (!cur_slot && en_b) begin
                        next_state = ST_OFFSET; // RULE_24
                        next_slot = 1'b1;
                        next_timer = 16'(ppgss_pkg::OFFSET_CYC - 1);
                    end else begin
                        next_state = ST_SLEEP;
                        next_timer = 16'(SLEEP_CYC - 1); // RULE_23
                    end
                end
                ST_SLEEP: if (timer_done) next_state = ST_IDLE;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            cur_slot <= 1'b0;
            timer <= '0;
            left <= '0;
            red_emitter <= 1'b0;
            infrared_emitter <= 1'b0;
            afe_window <= 1'b0;
        end else begin
            state <= next_state;
            cur_slot <= next_slot;
            timer <= next_timer;
            left <= next_left;
            red_emitter <= next_state == ST_PULSE && !next_slot; // RULE_14
            infrared_emitter <= next_state == ST_PULSE && next_slot;
            afe_window <= next_state == ST_PULSE; // RULE_14
        end
    end

    // ------------------------------------------------------------
    // Burst and sample accumulators, one per slot
    // ------------------------------------------------------------
    wire adc_take = adc_valid && (state == ST_PULSE || state == ST_GAP);
    wire wide_raw = cfg[ppgss_pkg::CFG_WIDE_RAW];
    wire fifo_both = en_a && en_b && (lg_a == lg_b); // RULE_20
    wire [1:0] fifo_mask = fifo_both ? 2'h3 :
                           (cfg[ppgss_pkg::CFG_FIFO_SEL] ? 2'h2 : 2'h1);
    wire [1:0] upd;

    for (genvar i = 0; i < 2; i++) begin : g_slot
        logic [ppgss_pkg::BURST_W-1:0] burst;
        logic [ppgss_pkg::SACC_W-1:0] sacc;
        logic [6:0] scnt;
        logic [ppgss_pkg::WIDE_W-1:0] wide;
        logic [ppgss_pkg::NARROW_W-1:0] narrow;
        wire [2:0] lg = (i == 0) ? lg_a : lg_b;
        wire mine = (cur_slot == 1'(i));
        wire [ppgss_pkg::BURST_W:0] bsum = {1'b0, burst} +
            {{(ppgss_pkg::BURST_W+1-ppgss_pkg::ADC_W){1'b0}}, adc_data};
        wire [ppgss_pkg::BURST_W-1:0] bsat =
            bsum[ppgss_pkg::BURST_W] ? '1 : bsum[ppgss_pkg::BURST_W-1:0];
        wire [ppgss_pkg::SACC_W-1:0] total = (scnt == 7'h00 ? '0 : sacc) +
            {{(ppgss_pkg::SACC_W-ppgss_pkg::BURST_W){1'b0}}, burst};
        wire [7:0] nm1 = (8'h01 << lg) - 8'h01;
        wire last = ({1'b0, scnt} == nm1); // RULE_07
        wire [ppgss_pkg::SACC_W-1:0] avg = total >> lg;
        wire [ppgss_pkg::WIDE_W-1:0] wide_next = wide_raw
            ? {{(ppgss_pkg::WIDE_W-ppgss_pkg::SACC_W){1'b0}}, total}
            : {{(ppgss_pkg::WIDE_W-ppgss_pkg::BURST_W){1'b0}},
               avg[ppgss_pkg::BURST_W-1:0]}; // RULE_17 RULE_19
        wire [ppgss_pkg::NARROW_W-1:0] narrow_next =
            (|avg[ppgss_pkg::SACC_W-1:ppgss_pkg::NARROW_W]) ? '1
            : avg[ppgss_pkg::NARROW_W-1:0]; // RULE_18
        wire end_i = slot_end && mine;
        assign upd[i] = end_i && last;

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                burst <= '0;
                sacc <= '0;
                scnt <= '0;
                wide <= '0;
                narrow <= '0;
            end else begin
                if (state == ST_OFFSET && mine) begin
                    burst <= '0;
                end else if (adc_take && mine) begin
                    burst <= bsat; // RULE_15 RULE_16
                end
                if (end_i) begin
                    sacc <= total; // RULE_17
                    scnt <= last ? 7'h00 : scnt + 7'h01;
                end
                if (upd[i]) begin
                    wide <= wide_next; // RULE_07
                    narrow <= narrow_next; // RULE_18
                end
            end
        end
    end

    // ------------------------------------------------------------
    // FIFO word buffer and register reads
    // ------------------------------------------------------------
    ppgss_pkg::ppgss_word_t push_word;
    assign push_word.slot = cur_slot;
    assign push_word.data = cur_slot ? g_slot[1].wide_next
                                     : g_slot[0].wide_next;
    wire push = |(upd & fifo_mask); // RULE_20

    ppgss_buf #(
        .WIDTH($bits(ppgss_pkg::ppgss_word_t)),
        .DEPTH(2)
    ) u_buf (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(push),
        .in_ready(),
        .in_data(push_word),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_word),
        .empty(buf_empty)
    );

    wire [7:0] ra = reg_req.addr;
    wire [15:0] rd_mux =
        ra == ppgss_pkg::ADDR_MODE ? {14'h0000, mode} :
        ra == ppgss_pkg::ADDR_CFG ? cfg :
        ra == ppgss_pkg::ADDR_RATE ? rate :
        ra == ppgss_pkg::ADDR_PULSE_A ? pulse_a :
        ra == ppgss_pkg::ADDR_PULSE_B ? pulse_b :
        ra == ppgss_pkg::ADDR_SLOT_SYNC ? slot_sync :
        ra == ppgss_pkg::ADDR_EXT_SYNC ? ext_sync :
        ra == ppgss_pkg::ADDR_WIDE_A_LO ? g_slot[0].wide[15:0] :
        ra == ppgss_pkg::ADDR_WIDE_A_HI ? g_slot[0].wide[31:16] :
        ra == ppgss_pkg::ADDR_WIDE_B_LO ? g_slot[1].wide[15:0] :
        ra == ppgss_pkg::ADDR_WIDE_B_HI ? g_slot[1].wide[31:16] :
        ra == ppgss_pkg::ADDR_NARROW_A ? g_slot[0].narrow :
        ra == ppgss_pkg::ADDR_NARROW_B ? g_slot[1].narrow : 16'h0000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_req.rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_standby_quiet: assert property ( // RULE_01
        mode == ppgss_pkg::MODE_STANDBY ##1 mode == ppgss_pkg::MODE_STANDBY
        |-> state == ST_IDLE && !afe_window && !red_emitter)
        else $error("standby mode is not idle");
    a_program_quiet: assert property ( // RULE_03
        (mode == ppgss_pkg::MODE_PROGRAM) [*2] |=> !afe_window)
        else $error("emitter pulsed in program mode");
    a_timer_start: assert property ( // RULE_08
        timer_fire |=> pending)
        else $error("rate divider expiry did not request a period");
    a_sync_start: assert property ( // RULE_11
        sync_arm && sync_half && tick && is_sample |=> pending)
        else $error("sync edge did not start a period");
    a_led_select: assert property ( // RULE_14
        red_emitter |-> $past(next_state) == ST_PULSE && !cur_slot
        && !infrared_emitter)
        else $error("wrong emitter for slot");
    a_burst_sat: assert property ( // RULE_16
        adc_take && !cur_slot && state != ST_OFFSET &&
        g_slot[0].bsum[ppgss_pkg::BURST_W]
        |=> g_slot[0].burst == '1)
        else $error("burst sum wrapped");
    a_proc_time: assert property ( // RULE_22
        state != ST_PROC ##1 state == ST_PROC |->
        timer == (cur_slot ? 16'(ppgss_pkg::PROC_B_CYC - 1)
                           : 16'(PROC_A_CYC - 1)))
        else $error("processing time load wrong");
    a_sleep_min: assert property ( // RULE_23
        state == ST_PROC ##1 state == ST_SLEEP |->
        timer == 16'(SLEEP_CYC - 1))
        else $error("sleep time load wrong");
    a_slot_order: assert property ( // RULE_24
        state == ST_PROC && !cur_slot && timer_done && en_b && is_sample
        |=> state == ST_OFFSET && cur_slot)
        else $error("slot B did not follow slot A");

endmodule // ppgss_sequencer

/* File: bench/ppgss_far_model.sv */
`timescale 1ns/1ps
// ----
// Far side: converter strobes and a stalling reader.
// ----
module ppgss_far_model #(
    parameter logic [13:0] VAL = 14'h3fff
) (
    // Clock
    input wire logic clk,
    // Converter and stream
    input wire logic afe_window,
    output logic adc_valid,
    output logic [13:0] adc_data,
    output logic out_ready
);
    logic win_d = 1'b0;
    logic [1:0] cnt = 2'h0;
    initial begin
        adc_valid = 1'b0;
        adc_data = ~VAL;
        out_ready = 1'b0;
    end
    always @(posedge clk) begin
        #1;
        adc_valid = afe_window && !win_d;
        adc_data = adc_valid ? VAL : ~VAL;
        win_d = afe_window;
        cnt = cnt + 2'h1;
        out_ready = (cnt == 2'h0);
    end
endmodule // ppgss_far_model

/* File: bench/ppg_sample_sequencer_tb.sv */
`timescale 1ns/1ps
module ppg_sample_sequencer_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    ppgss_pkg::ppgss_regreq_t req = '0;
    logic [15:0] rdata, d;
    logic adc_valid, red, ir, win, ov, ordy, hit;
    logic sync = 1'b0;
    logic [13:0] adc_data;
    ppgss_pkg::ppgss_word_t word;
    logic [32:0] w;
    logic [39:0] rows [8];
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int k;
    always #5 clk = ~clk;
    ppgss_sequencer #(.PROC_A_CYC(20), .SLEEP_CYC(20)) ppgss_sequencer_i (
        .clk(clk), .arst_n(arst_n), .reg_req(req), .reg_rdata(rdata),
        .int_pin(sync), .adc_valid(adc_valid), .adc_data(adc_data),
        .red_emitter(red), .infrared_emitter(ir), .afe_window(win),
        .out_valid(ov), .out_ready(ordy), .out_word(word));
    ppgss_far_model ppgss_far_model_i (.clk(clk), .afe_window(win),
        .adc_valid(adc_valid), .adc_data(adc_data), .out_ready(ordy));
    task automatic chk(input logic [32:0] s, input logic [32:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        #1 req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        #1 req.rd = 1'b0;
        @(posedge clk);
        #1 d = rdata;
    endtask
    task automatic get;
        w = 'x;
        for (k = 0; k < 30000; k++) begin
            @(negedge clk);
            if (ov === 1'b1 && ordy === 1'b1) begin
                w = word;
                break;
            end
        end
        @(posedge clk);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        rows = '{{8'h10, 16'h0001, 16'h0001},
            {8'h12, 16'h0005, 16'h0005},
            {8'h38, 16'h4000, 16'h4000}, {8'h4f, 16'h0000, 16'h0000},
            {8'h31, 16'h0200, 16'h0200}, {8'h36, 16'h0200, 16'h0200},
            {8'h11, 16'h2300, 16'h2300}, {8'h20, 16'h1234, 16'h0000}};
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        rd(ppgss_pkg::ADDR_MODE);
        chk({17'h0, d}, 33'h0);
        chk({30'h0, red, ir, win}, 33'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i][39:32], rows[i][31:16]);
            rd(rows[i][39:32]);
            chk({17'h0, d}, {17'h0, rows[i][15:0]});
        end
        $display("test registers done");
        wr(ppgss_pkg::ADDR_MODE, 16'h0002);
        get();
        chk(w, {1'b0, 32'h7ffe});
        get();
        chk(w, {1'b1, 32'h7ffe});
        $display("test raw sample done");
        wr(ppgss_pkg::ADDR_MODE, 16'h0001);
        wr(ppgss_pkg::ADDR_CFG, 16'h0311);
        wr(ppgss_pkg::ADDR_EXT_SYNC, 16'h0006);
        wr(ppgss_pkg::ADDR_SLOT_SYNC, 16'h4000);
        wr(ppgss_pkg::ADDR_MODE, 16'h0002);
        @(posedge clk);
        #1 sync = 1'b1;
        repeat (15000) @(posedge clk);
        #1 sync = 1'b0;
        @(posedge clk);
        #1 sync = 1'b1;
        get();
        chk(w, {1'b0, 32'h7ffe});
        get();
        chk(w, {1'b1, 32'h7ffe});
        rd(ppgss_pkg::ADDR_NARROW_A);
        chk({17'h0, d}, 33'h7ffe);
        rd(ppgss_pkg::ADDR_WIDE_B_HI);
        chk({17'h0, d}, 33'h0);
        $display("test sync averaging done");
        wr(ppgss_pkg::ADDR_MODE, 16'h0001);
        wr(ppgss_pkg::ADDR_MODE, 16'h0000);
        hit = 1'b0;
        for (k = 0; k < 8000; k++) begin
            @(negedge clk);
            if (red !== 1'b0 || ir !== 1'b0) hit = 1'b1;
        end
        chk({32'h0, hit}, 33'h0);
        rd(ppgss_pkg::ADDR_CFG);
        chk({17'h0, d}, 33'h0311);
        $display("test standby done");
        end_sim();
    end
endmodule // ppg_sample_sequencer_tb
